// ### core/tw_pkg.sv
package tw_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_NS        = 40;
	localparam int SCL_PERIOD_NS = 10000;
	// Least time per quarter of a bus clock, rounded up
	localparam int QUARTER_CYC   = (SCL_PERIOD_NS + 4 * CLK_NS - 1) /
		(4 * CLK_NS);
	// Longest self-timed write, and slots spent on one polling attempt
	localparam int WR_TIME_NS    = 5000000;
	localparam int POLL_SLOTS    = 11;
	localparam int POLL_LIMIT    = WR_TIME_NS /
		(SCL_PERIOD_NS * POLL_SLOTS) + 1;

	// ****************************************************************
	// Device address word and memory layout
	// ****************************************************************
	localparam logic [3:0] DEV_CODE   = 4'ha;
	localparam int         PAGE_BYTES = 16;
	localparam int         FIFO_DEPTH = 8;
	localparam int         DATA_W     = 8;

	// ****************************************************************
	// Command carrier
	// ****************************************************************
	typedef enum logic [2:0] {
		OP_WRITE     = 3'h0,
		OP_READ_CUR  = 3'h1,
		OP_READ_RAND = 3'h2,
		OP_POLL      = 3'h3,
		OP_RECOVER   = 3'h4
	} tw_op_type;

	typedef struct packed {
		tw_op_type   op;
		logic [9:0]  addr;
		logic [4:0]  count;
	} tw_cmd_type;

	typedef struct packed {
		logic scl_oe;
		logic sda_oe;
	} tw_drive_type;

endpackage

// ### core/tw_sync.sv
`timescale 1ns/1ps
module tw_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Signals
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule // tw_sync

// ### core/tw_fifo.sv
`timescale 1ns/1ps
module tw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    wr_d;
	logic [AW-1:0]    rd_q;
	logic [AW-1:0]    rd_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		mem_q <= mem_d;
	end
endmodule // tw_fifo

// ### core/tw_host.sv
`timescale 1ns/1ps
// Contract
// - Data changes only while clock is low.
// - Every command begins with a start condition.
// - Recovery: start, nine clocks, start, stop.
// - Byte write: address, word address, data, stop.
// - At most sixteen data bytes per page write.
// - Poll with start and address until acknowledged; the code gives up and raises err after POLL_LIMIT + 1 refused attempts.
// - Last read byte gets no acknowledge, then stop.
// - Random read: dummy write, repeated start, read.
// - Acknowledge each read byte to continue reading.
// - Five-lead part: pin select bits sent as zero.
module tw_host #(
	parameter bit LARGE      = 1'b0,
	parameter int QUARTER    = tw_pkg::QUARTER_CYC,
	parameter int POLL_LIMIT = tw_pkg::POLL_LIMIT,
	parameter int FIFO_DEPTH = tw_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// Command
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  wire tw_pkg::tw_cmd_type cmd,
	output logic                    busy,
	output logic                    done,
	output logic                    err,
	// Write data
	input  wire logic               wr_valid,
	output logic                    wr_ready,
	input  wire logic [7:0]         wr_data,
	// Read data
	output logic                    rd_valid,
	output logic [7:0]              rd_data,
	// Straps
	input  wire logic               addr_pin_high,
	input  wire logic               addr_pin_low,
	input  wire logic               five_lead,
	// Bus pins
	input  wire logic               scl_i,
	output logic                    scl_o,
	output logic                    scl_oe,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_START = 2'h1,
		ST_BIT   = 2'h2,
		ST_STOP  = 2'h3
	} tw_state_type;

	typedef enum logic [2:0] {
		SQ_DEVW    = 3'h0,
		SQ_WADDR   = 3'h1,
		SQ_WDATA   = 3'h2,
		SQ_DEVR    = 3'h3,
		SQ_RDATA   = 3'h4,
		SQ_REC     = 3'h5,
		SQ_RECSTOP = 3'h6
	} tw_seq_type;

	localparam int QW = $clog2(QUARTER + 1);
	localparam int PW = $clog2(POLL_LIMIT + 1);

	// ****************************************************************
	// Device address word
	// ****************************************************************
	function automatic logic [7:0] dev_byte(input logic rd,
		input logic [1:0] pg, input logic hi, input logic lo,
		input logic five);
		logic b3;
		logic b2;
		b3 = hi & ~five;
		b2 = LARGE ? pg[1] : (lo & ~five);
		return {tw_pkg::DEV_CODE, b3, b2, pg[0], rd};
	endfunction

	tw_state_type        st_q;
	tw_state_type        st_d;
	tw_seq_type          seq_q;
	tw_seq_type          seq_d;
	tw_pkg::tw_op_type   op_q;
	tw_pkg::tw_op_type   op_d;
	tw_pkg::tw_drive_type drv_q;
	tw_pkg::tw_drive_type drv_d;
	logic [1:0]          ph_q;
	logic [1:0]          ph_d;
	logic [QW-1:0]       qc_q;
	logic [QW-1:0]       qc_d;
	logic [3:0]          bit_q;
	logic [3:0]          bit_d;
	logic [7:0]          tx_q;
	logic [7:0]          tx_d;
	logic [7:0]          rx_q;
	logic [7:0]          rx_d;
	logic [4:0]          rem_q;
	logic [4:0]          rem_d;
	logic [9:0]          addr_q;
	logic [9:0]          addr_d;
	logic [PW-1:0]       poll_q;
	logic [PW-1:0]       poll_d;
	logic                ack_q;
	logic                ack_d;
	logic                retry_q;
	logic                retry_d;
	logic                err_q;
	logic                err_d;
	logic                done_q;
	logic                done_d;
	logic                rdv_q;
	logic                rdv_d;
	logic [7:0]          rdd_q;
	logic [7:0]          rdd_d;
	logic [4:0]          pin_s;
	logic                scl_s;
	logic                sda_s;
	logic                pin_hi_s;
	logic                pin_lo_s;
	logic                five_s;
	logic                fifo_valid;
	logic                fifo_pop;
	logic [7:0]          fifo_data;
	logic                adv;
	logic                hold;
	logic                stall;
	logic                slot_end;
	logic                need_data;
	logic                is_tx;
	logic [4:0]          cnt_one;
	logic [4:0]          cnt_m1;

	// ****************************************************************
	// Pin synchronisers and write-data buffer
	// ****************************************************************
	tw_sync #(.WIDTH(5)) u_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in ({scl_i, sda_i, addr_pin_high, addr_pin_low, five_lead}),
		.sync_out (pin_s)
	);
	assign {scl_s, sda_s, pin_hi_s, pin_lo_s, five_s} = pin_s;

	tw_fifo #(.WIDTH(tw_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// ****************************************************************
	// Slot timing
	// ****************************************************************
	assign need_data = (st_q == ST_BIT) && (bit_q == 4'd8) && ack_q &&
		(((seq_q == SQ_WADDR) && (op_q == tw_pkg::OP_WRITE)) ||
		((seq_q == SQ_WDATA) && (rem_q != 5'd0)));
	// Clock is held low while the buffer runs dry
	assign stall     = need_data && (ph_q == 2'd3) && !fifo_valid;
	assign hold      = ((ph_q == 2'd1) && !scl_s) || stall;
	assign adv       = (st_q != ST_IDLE) && (qc_q == QW'(QUARTER - 1)) &&
		!hold;
	assign slot_end  = adv && (ph_q == 2'd3);
	assign fifo_pop  = slot_end && need_data;
	assign is_tx     = (seq_q == SQ_DEVW) || (seq_q == SQ_WADDR) ||
		(seq_q == SQ_WDATA) || (seq_q == SQ_DEVR);
	assign cnt_one   = (cmd.count == 5'd0) ? 5'd1 : cmd.count;
	assign cnt_m1    = ((cmd.op == tw_pkg::OP_WRITE) &&
		(cnt_one > 5'(tw_pkg::PAGE_BYTES))) ?
		5'(tw_pkg::PAGE_BYTES - 1) : cnt_one - 5'd1;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		st_d    = st_q;
		seq_d   = seq_q;
		op_d    = op_q;
		ph_d    = ph_q;
		bit_d   = bit_q;
		tx_d    = tx_q;
		rx_d    = rx_q;
		rem_d   = rem_q;
		addr_d  = addr_q;
		poll_d  = poll_q;
		ack_d   = ack_q;
		retry_d = retry_q;
		err_d   = err_q;
		done_d  = 1'b0;
		rdv_d   = 1'b0;
		rdd_d   = rdd_q;
		qc_d    = (st_q == ST_IDLE || adv) ? '0 :
			(qc_q == QW'(QUARTER - 1)) ? qc_q : qc_q + 1'b1;
		if (adv) ph_d = ph_q + 2'd1;
		if (adv && (ph_q == 2'd2) && (st_q == ST_BIT)) begin
			if (bit_q == 4'd8) ack_d = !sda_s;
			else rx_d = {rx_q[6:0], sda_s};
		end
		case (st_q)
		ST_IDLE: begin
			ph_d = 2'd0;
			if (cmd_valid) begin
				st_d    = ST_START;
				op_d    = cmd.op;
				addr_d  = cmd.addr;
				rem_d   = cnt_m1;
				err_d   = 1'b0;
				retry_d = 1'b0;
				poll_d  = PW'(POLL_LIMIT);
				case (cmd.op)
				tw_pkg::OP_READ_CUR: seq_d = SQ_DEVR;
				tw_pkg::OP_RECOVER: seq_d = SQ_REC;
				default: seq_d = SQ_DEVW;
				endcase
			end
		end
		ST_START: if (slot_end) begin
			bit_d = 4'd0;
			st_d  = ST_BIT;
			case (seq_q)
			SQ_REC: tx_d = 8'hff;
			SQ_RECSTOP: st_d = ST_STOP;
			SQ_DEVR: tx_d = dev_byte(1'b1, addr_q[9:8], pin_hi_s, pin_lo_s,
				five_s);
			default: tx_d = dev_byte(1'b0, addr_q[9:8], pin_hi_s, pin_lo_s,
				five_s);
			endcase
		end
		ST_BIT: if (slot_end) begin
			if (bit_q != 4'd8) begin
				bit_d = bit_q + 4'd1;
				tx_d  = {tx_q[6:0], 1'b1};
			end else begin
				bit_d = 4'd0;
				st_d  = ST_STOP;
				case (seq_q)
				SQ_DEVW: if (op_q == tw_pkg::OP_POLL) begin
					retry_d = !ack_q && (poll_q != '0);
					poll_d  = ack_q ? poll_q : poll_q - 1'b1;
					err_d   = !ack_q && (poll_q == '0);
				end else if (ack_q) begin
					st_d  = ST_BIT;
					seq_d = SQ_WADDR;
					tx_d  = addr_q[7:0];
				end else begin
					err_d = 1'b1;
				end
				SQ_WADDR: if (!ack_q) begin
					err_d = 1'b1;
				end else if (op_q == tw_pkg::OP_READ_RAND) begin
					st_d  = ST_START;
					seq_d = SQ_DEVR;
				end else begin
					st_d  = ST_BIT;
					seq_d = SQ_WDATA;
					tx_d  = fifo_data;
				end
				SQ_WDATA: if (!ack_q) begin
					err_d = 1'b1;
				end else if (rem_q != 5'd0) begin
					st_d  = ST_BIT;
					tx_d  = fifo_data;
					rem_d = rem_q - 5'd1;
				end
				SQ_DEVR: if (!ack_q) begin
					err_d = 1'b1;
				end else begin
					st_d  = ST_BIT;
					seq_d = SQ_RDATA;
					tx_d  = 8'hff;
				end
				SQ_RDATA: begin
					rdv_d = 1'b1;
					rdd_d = rx_q;
					if (rem_q != 5'd0) begin
						st_d  = ST_BIT;
						rem_d = rem_q - 5'd1;
					end
				end
				SQ_REC: begin
					st_d  = ST_START;
					seq_d = SQ_RECSTOP;
				end
				default: err_d = 1'b1;
				endcase
			end
		end
		ST_STOP: if (slot_end) begin
			if (retry_q) begin
				st_d    = ST_START;
				seq_d   = SQ_DEVW;
				retry_d = 1'b0;
			end else begin
				st_d   = ST_IDLE;
				done_d = 1'b1;
			end
		end
		default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q    <= ST_IDLE;
			seq_q   <= SQ_DEVW;
			op_q    <= tw_pkg::OP_WRITE;
			ph_q    <= 2'd0;
			qc_q    <= '0;
			bit_q   <= 4'd0;
			tx_q    <= 8'hff;
			rx_q    <= 8'h00;
			rem_q   <= 5'd0;
			addr_q  <= 10'h000;
			poll_q  <= '0;
			ack_q   <= 1'b0;
			retry_q <= 1'b0;
			err_q   <= 1'b0;
			done_q  <= 1'b0;
			rdv_q   <= 1'b0;
			rdd_q   <= 8'h00;
		end else begin
			st_q    <= st_d;
			seq_q   <= seq_d;
			op_q    <= op_d;
			ph_q    <= ph_d;
			qc_q    <= qc_d;
			bit_q   <= bit_d;
			tx_q    <= tx_d;
			rx_q    <= rx_d;
			rem_q   <= rem_d;
			addr_q  <= addr_d;
			poll_q  <= poll_d;
			ack_q   <= ack_d;
			retry_q <= retry_d;
			err_q   <= err_d;
			done_q  <= done_d;
			rdv_q   <= rdv_d;
			rdd_q   <= rdd_d;
		end
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	always_comb begin
		drv_d = drv_q;
		case (st_q)
		ST_START: begin
			drv_d.scl_oe = (ph_q == 2'd0) ? drv_q.scl_oe : (ph_q == 2'd3);
			drv_d.sda_oe = ph_q[1];
		end
		ST_BIT: begin
			drv_d.scl_oe = (ph_q == 2'd0) || (ph_q == 2'd3);
			if (bit_q == 4'd8)
				drv_d.sda_oe = (seq_q == SQ_RDATA) && (rem_q != 5'd0);
			else
				drv_d.sda_oe = is_tx && !tx_q[7];
		end
		ST_STOP: begin
			drv_d.scl_oe = (ph_q == 2'd0);
			drv_d.sda_oe = !ph_q[1];
		end
		default: drv_d = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) drv_q <= '0;
		else drv_q <= drv_d;
	end

	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = drv_q.scl_oe;
	assign sda_oe    = drv_q.sda_oe;
	assign cmd_ready = st_q == ST_IDLE;
	assign busy      = st_q != ST_IDLE;
	assign done      = done_q;
	assign err       = err_q;
	assign rd_valid  = rdv_q;
	assign rd_data   = rdd_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_data_scl_low: assert property (
		($past(st_q) == ST_BIT) && $changed(drv_q.sda_oe) |->
		drv_q.scl_oe && $past(drv_q.scl_oe))
		else $error("data changed while clock released");
	a_start_first: assert property (
		cmd_valid && cmd_ready |=> (st_q == ST_START) ##1
		(st_q == ST_START)[*3])
		else $error("command not opened by start slot");
	a_stop_write: assert property (
		slot_end && (st_q == ST_BIT) && (seq_q == SQ_WDATA) &&
		(bit_q == 4'd8) && (rem_q == 5'd0) |=> st_q == ST_STOP)
		else $error("no stop after last write byte");
	a_page_limit: assert property (
		(st_q != ST_IDLE) && (op_q == tw_pkg::OP_WRITE) |->
		rem_q < 5'(tw_pkg::PAGE_BYTES))
		else $error("page write longer than sixteen bytes");
	a_poll_retry: assert property (
		slot_end && (st_q == ST_STOP) && retry_q |=>
		(st_q == ST_START) && (seq_q == SQ_DEVW))
		else $error("poll retry did not restart");
	a_last_nack: assert property (
		(st_q == ST_BIT) && (seq_q == SQ_RDATA) && (bit_q == 4'd8) &&
		(ph_q == 2'd1) && (rem_q == 5'd0) |=> !drv_q.sda_oe)
		else $error("last read byte acknowledged");
	a_ack_more: assert property (
		(st_q == ST_BIT) && (seq_q == SQ_RDATA) && (bit_q == 4'd8) &&
		(ph_q == 2'd1) && (rem_q != 5'd0) |=> drv_q.sda_oe)
		else $error("read byte not acknowledged");
	a_rand_restart: assert property (
		slot_end && (st_q == ST_BIT) && (seq_q == SQ_WADDR) &&
		(bit_q == 4'd8) && ack_q && (op_q == tw_pkg::OP_READ_RAND) |=>
		(st_q == ST_START) && (seq_q == SQ_DEVR))
		else $error("random read without repeated start");
	a_five_zero: assert property (
		(st_q == ST_BIT) && (seq_q == SQ_DEVW) && (bit_q == 4'd0) &&
		five_s && $stable(five_s) |-> !tx_q[3] && (LARGE || !tx_q[2]))
		else $error("select bit not zero for five-lead part");
	a_recover_nine: assert property (
		slot_end && (st_q == ST_BIT) && (seq_q == SQ_REC) &&
		(bit_q == 4'd8) |=> (st_q == ST_START) && (seq_q == SQ_RECSTOP))
		else $error("recovery sequence broken");

	c_write_done: cover property (
		done_q && (op_q == tw_pkg::OP_WRITE) && !err_q);
	c_read_seq: cover property (rdv_q ##[1:1000] rdv_q);
	c_poll_retry: cover property (retry_q && (st_q == ST_STOP));
	c_recover: cover property (done_q && (op_q == tw_pkg::OP_RECOVER));
endmodule // tw_host

// ### verif/tw_eeprom_model.sv
`timescale 1ns/1ps
module tw_eeprom_model #(
	parameter bit LARGE = 1'b0,
	parameter int WR_NS = 4000
) (
	// Bus
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_pull,
	// Straps
	input  wire logic pin_high,
	input  wire logic pin_low,
	input  wire logic wp
);
	// ****************************************************************
	// Behavioural memory device on the open-drain bus
	// ****************************************************************
	typedef enum logic [2:0] {S_IDLE, S_DEV, S_WA, S_WD, S_RD} tw_mst_type;
	logic [7:0] mem [0:1023];
	logic [7:0] pdat [0:15];
	logic [15:0] pval;
	logic [9:0] ctr;
	logic [9:0] amask;
	logic [7:0] sh;
	logic [7:0] cur;
	logic [1:0] pg;
	logic       wr_busy;
	int         bitn;
	tw_mst_type st;

	initial begin
		sda_pull = 1'b0;
		st = S_IDLE;
		bitn = 0;
		pval = 16'h0000;
		wr_busy = 1'b0;
		ctr = 10'h000;
		amask = LARGE ? 10'h3ff : 10'h1ff;
		for (int i = 0; i < 1024; i++)
			mem[i] = 8'(i) ^ 8'ha5;
	end

	always @(negedge sda) if (scl === 1'b1) begin
		st = S_DEV;
		bitn = 0;
	end

	// Stop commits the staged page and starts the timed write
	always @(posedge sda) if (scl === 1'b1) begin
		st = S_IDLE;
		if (pval != 16'h0000 && !wr_busy) begin
			for (int i = 0; i < 16; i++)
				if (pval[i])
					mem[{ctr[9:4], 4'(i)}] = pdat[i];
			pval = 16'h0000;
			wr_busy = 1'b1;
			wr_busy <= #(WR_NS) 1'b0;
		end
	end

	always @(posedge scl) begin
		if (st == S_RD && bitn == 8 && sda !== 1'b0)
			st = S_IDLE;
		else if (bitn < 8)
			sh = {sh[6:0], sda};
		bitn = (bitn == 8) ? 0 : bitn + 1;
	end

	always @(negedge scl) begin
		sda_pull = 1'b0;
		if (bitn == 8 && st == S_DEV) begin
			if (sh[7:4] == 4'ha && sh[3] == pin_high && !wr_busy &&
				(LARGE || sh[2] == pin_low)) begin
				sda_pull = 1'b1;
				pg = LARGE ? sh[2:1] : {1'b0, sh[1]};
				st = sh[0] ? S_RD : S_WA;
			end else
				st = S_IDLE;
		end else if (bitn == 8 && st == S_WA) begin
			ctr = {pg, sh} & amask;
			sda_pull = 1'b1;
			st = S_WD;
		end else if (bitn == 8 && st == S_WD) begin
			sda_pull = 1'b1;
			if (!wp) begin
				pdat[ctr[3:0]] = sh;
				pval[ctr[3:0]] = 1'b1;
			end
			ctr[3:0] = ctr[3:0] + 4'h1;
		end else if (st == S_RD && bitn < 8) begin
			if (bitn == 0) begin
				cur = mem[ctr];
				ctr = (ctr + 10'h001) & amask;
			end
			sda_pull = !cur[7 - bitn];
		end
	end
endmodule // tw_eeprom_model

// ### verif/two_wire_eeprom_slave_access_test.sv
`timescale 1ns/1ps
module two_wire_eeprom_slave_access_test;
	typedef struct packed {
		logic [2:0] op;
		logic [9:0] addr;
		logic [4:0] count;
		logic       exp_err;
	} tw_row_type;

	logic               clk = 1'b0;
	logic               srst = 1'b1;
	logic               cmd_valid = 1'b0;
	tw_pkg::tw_cmd_type cmd = '0;
	logic               wr_valid = 1'b0;
	logic [7:0]         wr_data = 8'h00;
	logic               s_hi = 1'b1;
	logic               s_lo = 1'b0;
	logic               five = 1'b0;
	logic               m_hi = 1'b1;
	logic               m_lo = 1'b0;
	logic               wp = 1'b0;
	logic               cmd_ready, busy, done, err, wr_ready;
	logic               rd_valid, scl_oe, sda_oe, sda_pull;
	logic [7:0]         rd_data;
	wire logic          scl_line = !scl_oe;
	wire logic          sda_line = !(sda_oe || sda_pull);
	logic [7:0]         exp_mem [0:511];
	logic [8:0]         exp_ctr = 9'h000;
	int                 n_fail = 0;
	int                 n_compared = 0;
	int                 cyc = 0;
	tw_row_type         rows [13];

	tw_host #(.LARGE(1'b0), .QUARTER(2), .POLL_LIMIT(3)) dut (
		.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .busy(busy), .done(done), .err(err),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .addr_pin_high(s_hi),
		.addr_pin_low(s_lo), .five_lead(five), .scl_i(scl_line), .scl_o(),
		.scl_oe(scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe));

	tw_eeprom_model #(.WR_NS(4000)) dev (
		.scl(scl_line), .sda(sda_line), .sda_pull(sda_pull),
		.pin_high(m_hi), .pin_low(m_lo), .wp(wp));

	always #20 clk = ~clk;

	// ****************************************************************
	// Checking and transfer tasks
	// ****************************************************************
	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic push(input int n, input logic [7:0] base);
		for (int k = 0; k < n; k++) begin
			wr_valid <= 1'b1;
			wr_data <= 8'(base + k);
			do @(posedge clk); while (wr_ready !== 1'b1);
		end
		wr_valid <= 1'b0;
	endtask

	task automatic run(input tw_pkg::tw_op_type op, input logic [9:0] a,
		input logic [4:0] c, input logic ee);
		int n;
		int nr;
		logic rd;
		logic [8:0] s;
		logic [7:0] base;
		n = (c == 5'h00) ? 1 : int'(c);
		rd = (op == tw_pkg::OP_READ_CUR || op == tw_pkg::OP_READ_RAND);
		if (op == tw_pkg::OP_WRITE && n > 16)
			n = 16;
		s = (op == tw_pkg::OP_READ_CUR) ? exp_ctr : a[8:0];
		base = a[7:0] ^ 8'hc3;
		nr = 0;
		fork
			if (op == tw_pkg::OP_WRITE)
				push(n, base);
			begin
				// A long write first fills the buffer until it refuses
				if (op == tw_pkg::OP_WRITE && n > 8) begin
					repeat (12) @(posedge clk);
					check(wr_ready, 0);
				end
				cmd_valid <= 1'b1;
				cmd <= '{op, a, c};
				do @(posedge clk); while (cmd_ready !== 1'b1);
				cmd_valid <= 1'b0;
				do begin
					@(posedge clk);
					if (rd_valid === 1'b1) begin
						check(rd_data, exp_mem[s + 9'(nr)]);
						nr++;
					end
				end while (done !== 1'b1);
				check(err, ee);
				check(nr, (ee || !rd) ? 0 : n);
			end
		join
		if (!ee && op == tw_pkg::OP_WRITE) begin
			for (int k = 0; k < n; k++)
				if (!wp)
					exp_mem[{a[8:4], 4'(a[3:0] + k)}] = 8'(base + k);
			exp_ctr = {a[8:4], 4'(a[3:0] + n)};
		end
		if (!ee && rd)
			exp_ctr = s + 9'(n);
	endtask

	// Ceiling well above the roughly 8500 cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			give_verdict();
		end
	end

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		for (int i = 0; i < 512; i++)
			exp_mem[i] = 8'(i) ^ 8'ha5;
		rows = '{
			'{3'h0, 10'h010, 5'h01, 1'h0}, '{3'h3, 10'h000, 5'h00, 1'h0},
			'{3'h2, 10'h010, 5'h01, 1'h0}, '{3'h0, 10'h11e, 5'h10, 1'h0},
			'{3'h3, 10'h000, 5'h00, 1'h0}, '{3'h2, 10'h110, 5'h10, 1'h0},
			'{3'h1, 10'h000, 5'h02, 1'h0}, '{3'h2, 10'h1fe, 5'h03, 1'h0},
			'{3'h1, 10'h000, 5'h01, 1'h0}, '{3'h0, 10'h020, 5'h00, 1'h0},
			'{3'h2, 10'h030, 5'h01, 1'h1}, '{3'h3, 10'h000, 5'h00, 1'h0},
			'{3'h2, 10'h020, 5'h01, 1'h0}};
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		check(cmd_ready, 1);
		check(busy, 0);
		check(scl_oe, 0);
		check(sda_oe, 0);
		for (int i = 0; i < 13; i++)
			run(tw_pkg::tw_op_type'(rows[i].op), rows[i].addr, rows[i].count,
				rows[i].exp_err);
		// Wrong strap value leaves the device unselected
		s_lo <= 1'b1;
		repeat (4) @(posedge clk);
		run(tw_pkg::OP_READ_CUR, 10'h000, 5'h01, 1'b1);
		// Both low straps high: the pin bit goes out as one and matches
		m_lo <= 1'b1;
		run(tw_pkg::OP_POLL, 10'h000, 5'h00, 1'b0);
		s_lo <= 1'b0;
		m_lo <= 1'b0;
		// High strap wrong: device stays unselected
		s_hi <= 1'b0;
		repeat (4) @(posedge clk);
		run(tw_pkg::OP_READ_CUR, 10'h000, 5'h01, 1'b1);
		s_hi <= 1'b1;
		// Five-lead part: pin bits must go out as zero
		m_hi <= 1'b0;
		five <= 1'b1;
		repeat (4) @(posedge clk);
		run(tw_pkg::OP_POLL, 10'h000, 5'h00, 1'b0);
		m_hi <= 1'b1;
		five <= 1'b0;
		// Protected write is acknowledged, leaves memory untouched
		wp <= 1'b1;
		repeat (4) @(posedge clk);
		run(tw_pkg::OP_WRITE, 10'h050, 5'h02, 1'b0);
		run(tw_pkg::OP_POLL, 10'h000, 5'h00, 1'b0);
		wp <= 1'b0;
		run(tw_pkg::OP_READ_RAND, 10'h050, 5'h02, 1'b0);
		run(tw_pkg::OP_RECOVER, 10'h000, 5'h00, 1'b0);
		run(tw_pkg::OP_READ_CUR, 10'h000, 5'h01, 1'b0);
		give_verdict();
	end
endmodule // two_wire_eeprom_slave_access_test
